// ---- design/crops_ctrl.v ----
// Operand-size sequencer for calls, gate calls, interrupt entry and returns.
// Assumes a stack memory on the same clock: writes take push_*, reads
// answer pop_data while pop_req stands. Parameter source answers
// param_data combinationally for param_idx in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "crops_consts.vh"

module crops_ctrl (
  input  wire        core_clk,             // Core clock, 200 MHz
  input  wire        arst_n,               // Asynchronous reset, active low
  input  wire [7:0]  insn_byte,            // Decoded instruction byte
  input  wire        insn_byte_valid,      // Strobe for insn_byte
  input  wire        xfer_start,           // Start a transfer (pulse)
  input  wire [1:0]  xfer_kind,            // Pointer call, gate, interrupt, return
  input  wire        code_default_32,      // Calling code segment default size
  input  wire        stack_big,            // Stack-segment big flag
  input  wire        gate_is_32,           // Gate type is 32-bit
  input  wire [31:0] gate_offset,          // Destination offset held in gate
  input  wire [4:0]  gate_param_count,     // Gate parameter count field
  input  wire        priv_change,          // Transfer changes privilege level
  input  wire        same_or_more_priv,    // Target level same or more privileged
  input  wire [31:0] ptr_offset,           // Destination offset from pointer
  input  wire [31:0] insn_pointer_wide,    // Return address to save
  input  wire [31:0] stack_ptr_in,         // Stack pointer for the new stack
  input  wire [31:0] outer_stack_ptr,      // Caller stack pointer to save
  input  wire [31:0] param_data,           // Parameter at param_idx
  input  wire [31:0] pop_data,             // Stack read data
  output wire        busy,                 // Transfer in progress
  output wire        done,                 // Transfer finished (pulse)
  output wire        op_size_32,           // Operand size of last transfer
  output wire        push_valid,           // Stack write strobe (pulse)
  output wire [31:0] push_addr,            // Stack write address
  output wire [31:0] push_data,            // Stack write data
  output wire        push_wide,            // Stack write is 32 bits
  output wire        pop_req,              // Stack read strobe (pulse)
  output wire [31:0] pop_addr,             // Stack read address
  output wire        pop_wide,             // Stack read is 32 bits
  output wire [4:0]  param_idx,            // Parameter being copied
  output wire [31:0] stack_ptr_out,        // Current stack pointer
  output wire [31:0] insn_pointer_next,    // Resulting instruction pointer
  output wire        ret_addr_truncated,   // Interrupt return address lost upper bits
  output wire        stack_upper_undef     // Upper stack pointer half unreliable
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function is_prefix;
    input [7:0] b;
    begin
      is_prefix = (b == `CROPS_OPSIZE_PREFIX);
    end
  endfunction

  function [31:0] narrow_to_size;
    input [31:0] v;
    input        wide;
    begin
      narrow_to_size = wide ? v : {`CROPS_HALF_ZERO, v[15:0]};
    end
  endfunction

  function [31:0] stack_addr;
    input [31:0] sp;
    input        big;
    begin
      stack_addr = big ? sp : {`CROPS_HALF_ZERO, sp[15:0]};
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [`CROPS_ST_W-1:0]  state_reg;
  reg [`CROPS_ST_W-1:0]  state_next;
  reg                    prefix_reg;
  reg                    size32_reg;
  reg                    priv_reg;
  reg [`CROPS_CNT_W-1:0] cnt_reg;
  reg [`CROPS_CNT_W-1:0] param_idx_reg;
  reg [31:0]             sp_reg;
  reg [31:0]             target_reg;
  reg [31:0]             ret_ip_reg;
  reg [31:0]             outer_sp_reg;
  reg                    narrow_gate_call_reg;
  reg                    busy_reg;
  reg                    done_reg;
  reg                    push_valid_reg;
  reg [31:0]             push_addr_reg;
  reg [31:0]             push_data_reg;
  reg                    push_wide_reg;
  reg                    pop_req_reg;
  reg [31:0]             pop_addr_reg;
  reg                    pop_wide_reg;
  reg [31:0]             ip_out_reg;
  reg                    trunc_reg;
  reg                    undef_reg;

  wire        start_size32;
  wire        is_gate_kind;
  wire        dir_push;
  wire [31:0] sp_adj;

  // Prefix reverses the code default; gates and interrupts ignore it
  assign is_gate_kind = (xfer_kind == `CROPS_KIND_GATE) ||
                        (xfer_kind == `CROPS_KIND_INTR);
  assign start_size32 = is_gate_kind ? gate_is_32
                                     : (code_default_32 ^ prefix_reg);
  assign dir_push = (state_reg == `CROPS_ST_PUSH_SP) ||
                    (state_reg == `CROPS_ST_PUSH_PARM) ||
                    (state_reg == `CROPS_ST_PUSH_IP);

  crops_sp_adj u_sp_adj (
    .sp_in     (sp_reg),
    .stack_big (stack_big),
    .item_wide (size32_reg),
    .dir_push  (dir_push),
    .sp_out    (sp_adj)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `CROPS_ST_IDLE: begin
        if (xfer_start) begin
          if (xfer_kind == `CROPS_KIND_RETURN) begin
            state_next = `CROPS_ST_POP_IP;
          end else if (priv_change) begin
            state_next = `CROPS_ST_PUSH_SP;
          end else begin
            state_next = `CROPS_ST_PUSH_IP;
          end
        end
      end
      `CROPS_ST_PUSH_SP: begin
        state_next = (cnt_reg != `CROPS_CNT_ZERO) ? `CROPS_ST_PUSH_PARM
                                                 : `CROPS_ST_PUSH_IP;
      end
      `CROPS_ST_PUSH_PARM: begin
        if (param_idx_reg == cnt_reg - `CROPS_CNT_ONE) begin
          state_next = `CROPS_ST_PUSH_IP;
        end
      end
      `CROPS_ST_PUSH_IP:   state_next = `CROPS_ST_IDLE;
      `CROPS_ST_POP_IP:    state_next = `CROPS_ST_POP_IP_W;
      `CROPS_ST_POP_IP_W: begin
        state_next = priv_reg ? `CROPS_ST_POP_SP : `CROPS_ST_IDLE;
      end
      `CROPS_ST_POP_SP:    state_next = `CROPS_ST_POP_SP_W;
      `CROPS_ST_POP_SP_W:  state_next = `CROPS_ST_IDLE;
      default:             state_next = `CROPS_ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Prefix tracking
  // ----------------------------------------
  // A prefix seen in the start cycle belongs to the next instruction,
  // so the set wins over the clear by the consuming start.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prefix_reg <= 1'b0;
    end else if (insn_byte_valid && is_prefix(insn_byte)) begin
      prefix_reg <= 1'b1;
    end else if (xfer_start && state_reg == `CROPS_ST_IDLE) begin
      prefix_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg            <= `CROPS_ST_IDLE;
      size32_reg           <= 1'b0;
      priv_reg             <= 1'b0;
      cnt_reg              <= `CROPS_CNT_ZERO;
      param_idx_reg        <= `CROPS_CNT_ZERO;
      sp_reg               <= 32'h00000000;
      target_reg           <= 32'h00000000;
      ret_ip_reg           <= 32'h00000000;
      outer_sp_reg         <= 32'h00000000;
      narrow_gate_call_reg <= 1'b0;
      busy_reg             <= 1'b0;
      done_reg             <= 1'b0;
      push_valid_reg       <= 1'b0;
      push_addr_reg        <= 32'h00000000;
      push_data_reg        <= 32'h00000000;
      push_wide_reg        <= 1'b0;
      pop_req_reg          <= 1'b0;
      pop_addr_reg         <= 32'h00000000;
      pop_wide_reg         <= 1'b0;
      ip_out_reg           <= 32'h00000000;
      trunc_reg            <= 1'b0;
      undef_reg            <= 1'b0;
    end else begin
      state_reg      <= state_next;
      done_reg       <= 1'b0;
      push_valid_reg <= 1'b0;
      pop_req_reg    <= 1'b0;
      case (state_reg)
        `CROPS_ST_IDLE: begin
          if (xfer_start) begin
            busy_reg     <= 1'b1;
            size32_reg   <= start_size32;
            priv_reg     <= priv_change;
            sp_reg       <= stack_ptr_in;
            ret_ip_reg   <= insn_pointer_wide;
            outer_sp_reg <= outer_stack_ptr;
            param_idx_reg <= `CROPS_CNT_ZERO;
            trunc_reg    <= 1'b0;
            undef_reg    <= 1'b0;
            // Only call gates copy parameters, and only across levels
            cnt_reg <= (xfer_kind == `CROPS_KIND_GATE && priv_change) ?
                       gate_param_count : `CROPS_CNT_ZERO;
            // Gate offset is cut to the gate size; a pointer offset to the operand size
            target_reg <= is_gate_kind ?
                          narrow_to_size(gate_offset, gate_is_32)
                        : narrow_to_size(ptr_offset, start_size32);
            if (xfer_kind == `CROPS_KIND_GATE) begin
              narrow_gate_call_reg <= code_default_32 && !gate_is_32 &&
                                      same_or_more_priv;
            end
            if (xfer_kind == `CROPS_KIND_INTR && !gate_is_32 &&
                insn_pointer_wide > `CROPS_NARROW_MAX) begin
              trunc_reg <= 1'b1;
            end
          end
        end
        `CROPS_ST_PUSH_SP: begin
          sp_reg         <= sp_adj;
          push_valid_reg <= 1'b1;
          push_addr_reg  <= stack_addr(sp_adj, stack_big);
          push_data_reg  <= narrow_to_size(outer_sp_reg, size32_reg);
          push_wide_reg  <= size32_reg;
        end
        `CROPS_ST_PUSH_PARM: begin
          // Count unit is the gate's item size: word or doubleword
          sp_reg         <= sp_adj;
          push_valid_reg <= 1'b1;
          push_addr_reg  <= stack_addr(sp_adj, stack_big);
          push_data_reg  <= narrow_to_size(param_data, size32_reg);
          push_wide_reg  <= size32_reg;
          param_idx_reg  <= param_idx_reg + `CROPS_CNT_ONE;
        end
        `CROPS_ST_PUSH_IP: begin
          sp_reg         <= sp_adj;
          push_valid_reg <= 1'b1;
          push_addr_reg  <= stack_addr(sp_adj, stack_big);
          // Narrow save drops upper pointer bits; ret_addr_truncated flags it for interrupts only
          push_data_reg  <= narrow_to_size(ret_ip_reg, size32_reg);
          push_wide_reg  <= size32_reg;
          ip_out_reg     <= target_reg;
          busy_reg       <= 1'b0;
          done_reg       <= 1'b1;
        end
        `CROPS_ST_POP_IP: begin
          // Return trusts software to match the call's size
          pop_req_reg  <= 1'b1;
          pop_addr_reg <= stack_addr(sp_reg, stack_big);
          pop_wide_reg <= size32_reg;
          sp_reg       <= sp_adj;
        end
        `CROPS_ST_POP_IP_W: begin
          ip_out_reg <= narrow_to_size(pop_data, size32_reg);
          if (!priv_reg) begin
            busy_reg  <= 1'b0;
            done_reg  <= 1'b1;
            undef_reg <= narrow_gate_call_reg && stack_big;
            narrow_gate_call_reg <= 1'b0;
          end
        end
        `CROPS_ST_POP_SP: begin
          pop_req_reg  <= 1'b1;
          pop_addr_reg <= stack_addr(sp_reg, stack_big);
          pop_wide_reg <= size32_reg;
          sp_reg       <= sp_adj;
        end
        `CROPS_ST_POP_SP_W: begin
          // Narrow pop restores the low half only; upper half is stale
          sp_reg   <= size32_reg ? pop_data
                                 : {sp_reg[31:16], pop_data[15:0]};
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          narrow_gate_call_reg <= 1'b0;
        end
        default: begin
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign busy               = busy_reg;
  assign done               = done_reg;
  assign op_size_32         = size32_reg;
  assign push_valid         = push_valid_reg;
  assign push_addr          = push_addr_reg;
  assign push_data          = push_data_reg;
  assign push_wide          = push_wide_reg;
  assign pop_req            = pop_req_reg;
  assign pop_addr           = pop_addr_reg;
  assign pop_wide           = pop_wide_reg;
  assign param_idx          = param_idx_reg;
  assign stack_ptr_out      = sp_reg;
  assign insn_pointer_next  = ip_out_reg;
  assign ret_addr_truncated = trunc_reg;
  assign stack_upper_undef  = undef_reg;

endmodule // crops_ctrl
`default_nettype wire

// ---- design/crops_consts.vh ----
// Constants for the call/return operand-size sequencer.
// Assumes inclusion by bare name from the design files only.
`ifndef CROPS_CONSTS_VH
`define CROPS_CONSTS_VH

// ----------------------------------------
// Transfer kinds
// ----------------------------------------
`define CROPS_KIND_W        2
`define CROPS_KIND_PTR_CALL 2'h0
`define CROPS_KIND_GATE     2'h1
`define CROPS_KIND_INTR     2'h2
`define CROPS_KIND_RETURN   2'h3

// ----------------------------------------
// Prefix decode
// ----------------------------------------
`define CROPS_OPSIZE_PREFIX 8'h66

// ----------------------------------------
// Widths and limits
// ----------------------------------------
`define CROPS_NARROW_MAX    32'h0000ffff
`define CROPS_STEP_NARROW   32'h00000002
`define CROPS_STEP_WIDE     32'h00000004
`define CROPS_CNT_W         5
`define CROPS_CNT_ZERO      5'h00
`define CROPS_CNT_ONE       5'h01
`define CROPS_HALF_ZERO     16'h0000

// ----------------------------------------
// Sequencer states
// ----------------------------------------
`define CROPS_ST_W          3
`define CROPS_ST_IDLE       3'h0
`define CROPS_ST_PUSH_SP    3'h1
`define CROPS_ST_PUSH_PARM  3'h2
`define CROPS_ST_PUSH_IP    3'h3
`define CROPS_ST_POP_IP     3'h4
`define CROPS_ST_POP_IP_W   3'h5
`define CROPS_ST_POP_SP     3'h6
`define CROPS_ST_POP_SP_W   3'h7

`endif

// ---- design/crops_sp_adj.v ----
// Stack pointer adjuster for one pushed or popped item.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "crops_consts.vh"

module crops_sp_adj (
  input  wire [31:0] sp_in,      // Current stack pointer value
  input  wire        stack_big,  // Stack-segment big flag
  input  wire        item_wide,  // Item is 32 bits
  input  wire        dir_push,   // 1 push (decrement), 0 pop
  output reg  [31:0] sp_out      // Adjusted stack pointer
);

  reg [31:0] step;
  reg [31:0] full;

  always @* begin
    step = item_wide ? `CROPS_STEP_WIDE : `CROPS_STEP_NARROW;
    full = dir_push ? (sp_in - step) : (sp_in + step);
    // Narrow pointer wraps in 16 bits; upper half left untouched
    if (stack_big) begin
      sp_out = full;
    end else begin
      sp_out = {sp_in[31:16], full[15:0]};
    end
  end

endmodule // crops_sp_adj
`default_nettype wire

// ---- tb/crops_ctrl_monitor.sv ----
// Checker for the call/return operand-size sequencer.
// Assumes it is bound onto crops_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module crops_monitor (
  input wire        core_clk,      // Core clock
  input wire        arst_n,        // Async reset, low
  input wire        xfer_start,    // Start strobe
  input wire [1:0]  xfer_kind,     // Transfer kind
  input wire        priv_change,   // Level change
  input wire        gate_is_32,    // Gate type
  input wire        stack_big,     // Stack big flag
  input wire        busy,          // Busy level
  input wire        done,          // Done pulse
  input wire        op_size_32,    // Operand size
  input wire        push_valid,    // Push strobe
  input wire [31:0] push_addr,     // Push address
  input wire [31:0] push_data,     // Push data
  input wire        push_wide,     // Push width
  input wire        pop_req,       // Pop strobe
  input wire        pop_wide,      // Pop width
  input wire [31:0] stack_ptr_out  // Stack pointer
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire start_ok = xfer_start && !busy;

  ptr_call_time_a:
    assert property (start_ok && xfer_kind == 2'h0 && !priv_change |-> ##2 (done && push_valid))
    else $error("pointer call did not finish two cycles after start");
  gate_size_a:
    assert property (start_ok && xfer_kind[1] != xfer_kind[0] && !priv_change
      |-> ##2 (push_valid && push_wide == $past(gate_is_32, 2)))
    else $error("gate transfer push width differs from gate type");
  push_width_a:
    assert property (push_valid |-> push_wide == op_size_32)
    else $error("push width differs from operand size");
  narrow_zero_a:
    assert property (push_valid && !push_wide |-> push_data[31:16] == 16'h0000)
    else $error("narrow push carries upper bits");
  stack_window_a:
    assert property (push_valid && !stack_big
      |-> push_addr[31:16] == 16'h0000 && push_addr[15:0] == stack_ptr_out[15:0])
    else $error("narrow stack address wrong");
  push_step_a:
    assert property (push_valid && $past(push_valid)
      |-> push_addr[15:0] == $past(push_addr[15:0]) - (push_wide ? 16'h0004 : 16'h0002))
    else $error("push step size wrong");
  pop_width_a:
    assert property (pop_req |-> pop_wide == op_size_32)
    else $error("pop width differs from operand size");
  ret_time_a:
    assert property (start_ok && xfer_kind == 2'h3 && !priv_change
      |-> ##2 (pop_req && !done) ##[1:2] done)
    else $error("return did not pop then finish");
  done_shape_a:
    assert property (done |-> !busy ##1 !done)
    else $error("done not a single idle pulse");
endmodule // crops_monitor
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the operand-size sequencer.
// Assumes crops_ctrl and crops_monitor are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        core_clk          = 1'b0;
  logic        arst_n            = 1'b0;
  logic [7:0]  insn_byte         = 8'h00;
  logic        insn_byte_valid   = 1'b0;
  logic        xfer_start        = 1'b0;
  logic [1:0]  xfer_kind         = 2'h0;
  logic        code_default_32   = 1'b0;
  logic        stack_big         = 1'b0;
  logic        gate_is_32        = 1'b0;
  logic [4:0]  gate_param_count  = 5'h00;
  logic        priv_change       = 1'b0;
  logic        same_or_more_priv = 1'b1;
  logic [31:0] stack_ptr_in      = 32'h00000000;
  logic [31:0] pop_data;
  logic [31:0] pop_idle          = 32'h00000000;
  logic [31:0] gate_offset       = 32'habcd1234;
  logic [31:0] ptr_offset        = 32'h00024680;
  logic [31:0] insn_pointer_wide = 32'h00012344;
  logic [31:0] outer_stack_ptr   = 32'h00007ff0;
  wire  [31:0] param_data, push_addr, push_data, pop_addr, stack_ptr_out, insn_pointer_next;
  wire  [4:0]  param_idx;
  wire         busy, done, op_size_32, push_valid, push_wide, pop_req, pop_wide;
  wire         ret_addr_truncated, stack_upper_undef;
  int          n_fail = 0, compares = 0, cyc, np, c, tick = 0;
  logic [31:0] pa [8], pd [8], pw [8];

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] msk(input logic [31:0] v, input logic w);
    msk = w ? v : {16'h0000, v[15:0]};
  endfunction
  // Stack contents depend on the low address only, so narrow and wide views agree
  function automatic logic [31:0] popv(input logic [31:0] a);
    popv = {a[15:0] ^ 16'h5a5a, a[15:0] ^ 16'h0f0f};
  endfunction
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task pfx(input logic [7:0] b);
    @(posedge core_clk);
    insn_byte <= b;
    insn_byte_valid <= 1'b1;
    @(posedge core_clk);
    insn_byte_valid <= 1'b0;
  endtask
  task go(input logic [1:0] k, input logic d, g, p, b, input logic [4:0] n,
          input logic [31:0] sp);
    @(posedge core_clk);
    xfer_kind <= k;
    code_default_32 <= d;
    gate_is_32 <= g;
    priv_change <= p;
    stack_big <= b;
    gate_param_count <= n;
    stack_ptr_in <= sp;
    xfer_start <= 1'b1;
    @(posedge core_clk);
    xfer_start <= 1'b0;
    np = 0;
    // Count ends at the edge that raises done
    cyc = 1;
    while (done !== 1'b1 && cyc < 40) begin
      @(posedge core_clk);
      #1;
      cyc++;
      if (push_valid === 1'b1 && np < 8) begin
        pa[np] = push_addr;
        pd[np] = push_data;
        pw[np] = {31'h0, push_wide};
        np++;
      end
    end
    chk("done seen", {31'h0, done}, 32'h00000001);
  endtask

  assign param_data = 32'hc0de0000 + {27'h0, param_idx};
  always #2.5 core_clk = ~core_clk;
  // Read data answers while pop_req stands; idle value flips so stale data never matches
  always @(posedge core_clk) pop_idle <= ~pop_idle;
  always @* pop_data = pop_req ? popv(pop_addr) : pop_idle;
  always @(posedge core_clk) begin
    tick <= tick + 1;
    if (tick == 3000) begin
      n_fail++;
      test_done;
    end
  end

  crops_ctrl crops_ctrl_inst (
    .core_clk(core_clk), .arst_n(arst_n), .insn_byte(insn_byte),
    .insn_byte_valid(insn_byte_valid), .xfer_start(xfer_start), .xfer_kind(xfer_kind),
    .code_default_32(code_default_32), .stack_big(stack_big), .gate_is_32(gate_is_32),
    .gate_offset(gate_offset), .gate_param_count(gate_param_count),
    .priv_change(priv_change), .same_or_more_priv(same_or_more_priv),
    .ptr_offset(ptr_offset), .insn_pointer_wide(insn_pointer_wide),
    .stack_ptr_in(stack_ptr_in), .outer_stack_ptr(outer_stack_ptr),
    .param_data(param_data), .pop_data(pop_data), .busy(busy), .done(done),
    .op_size_32(op_size_32), .push_valid(push_valid), .push_addr(push_addr),
    .push_data(push_data), .push_wide(push_wide), .pop_req(pop_req), .pop_addr(pop_addr),
    .pop_wide(pop_wide), .param_idx(param_idx), .stack_ptr_out(stack_ptr_out),
    .insn_pointer_next(insn_pointer_next), .ret_addr_truncated(ret_addr_truncated),
    .stack_upper_undef(stack_upper_undef));

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    go(2'h0, 0, 0, 0, 0, 0, 32'h12340000);
    chk("cycles", cyc, 2);
    chk("push addr", pa[0], 32'h0000fffe);
    chk("push data", pd[0], 32'h00002344);
    chk("push wide", pw[0], 0);
    chk("stack ptr", stack_ptr_out, 32'h1234fffe);
    chk("target", insn_pointer_next, 32'h00004680);
    $display("test narrow call finished");
    pfx(8'h67);
    go(2'h0, 0, 0, 0, 1, 0, 32'h00000100);
    chk("other prefix", op_size_32, 0);
    pfx(8'h66);
    go(2'h0, 0, 0, 0, 1, 0, 32'h00000100);
    chk("prefixed addr", pa[0], 32'h000000fc);
    chk("prefixed data", pd[0], 32'h00012344);
    chk("prefixed target", insn_pointer_next, 32'h00024680);
    go(2'h0, 0, 0, 0, 1, 0, 32'h00000100);
    chk("prefix once", op_size_32, 0);
    pfx(8'h66);
    go(2'h0, 1, 0, 0, 1, 0, 32'h00000100);
    chk("prefix wide code", op_size_32, 0);
    $display("test prefix finished");
    for (int g = 0; g < 2; g++) begin
      c = 3 - g;
      go(2'h1, 0, g[0], 1, 1, c[4:0], 32'h00008000);
      chk("gate cycles", cyc, 3 + c);
      chk("gate pushes", np, c + 2);
      for (int i = 0; i < c + 2; i++)
        chk("gate addr", pa[i], 32'h00008000 - (g ? 4 : 2) * (i + 1));
      chk("outer sp", pd[0], 32'h00007ff0);
      chk("last param", pd[c], msk(32'hc0de0000 + c - 1, g[0]));
      chk("gate ret", pd[c + 1], msk(32'h00012344, g[0]));
      chk("gate target", insn_pointer_next, msk(32'habcd1234, g[0]));
      go(2'h2, 0, g[0], 0, 1, 0, 32'h00000200);
      chk("intr wide", pw[0], g);
      chk("intr data", pd[0], msk(32'h00012344, g[0]));
      chk("truncated", ret_addr_truncated, {31'h0, !g[0]});
      chk("intr target", insn_pointer_next, msk(32'habcd1234, g[0]));
    end
    $display("test gates finished");
    pfx(8'h66);
    go(2'h3, 0, 0, 0, 1, 0, 32'h00000300);
    chk("prefixed ret ip", insn_pointer_next, popv(32'h00000300));
    go(2'h3, 1, 0, 0, 1, 0, 32'h00000300);
    chk("ret ip", insn_pointer_next, popv(32'h00000300));
    chk("ret sp", stack_ptr_out, 32'h00000304);
    go(2'h3, 0, 0, 1, 0, 0, 32'h55550010);
    chk("ret narrow ip", insn_pointer_next, msk(popv(32'h00000010), 0));
    chk("ret narrow sp", stack_ptr_out, 32'h55550000 | msk(popv(32'h00000012), 0));
    go(2'h1, 1, 0, 0, 1, 0, 32'h00010400);
    go(2'h3, 0, 0, 0, 1, 0, 32'h000103fe);
    chk("upper undef", stack_upper_undef, 1);
    go(2'h0, 1, 0, 0, 1, 0, 32'h00010400);
    chk("flag cleared", stack_upper_undef, 0);
    $display("test returns finished");
    test_done;
  end
endmodule // tb_top

bind crops_ctrl crops_monitor crops_monitor_inst (
  .core_clk(core_clk), .arst_n(arst_n), .xfer_start(xfer_start), .xfer_kind(xfer_kind),
  .priv_change(priv_change), .gate_is_32(gate_is_32), .stack_big(stack_big),
  .busy(busy), .done(done), .op_size_32(op_size_32), .push_valid(push_valid),
  .push_addr(push_addr), .push_data(push_data), .push_wide(push_wide),
  .pop_req(pop_req), .pop_wide(pop_wide), .stack_ptr_out(stack_ptr_out));
`default_nettype wire
